//--- domain_reset_fifo_clock_select.sv
// Domain resets, FIFO clock selection and version readback
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Low power-on reset input resets whole chip
// R2 - Set bit holds its clock domain in reset
// R3 - Select bit one: FIFO on front clock
// R4 - Host picks the faster clock for FIFO
// R5 - Read-only fixed chip version code
// R6 - Clock management registers live in page zero
// R7 - Back-end clock drives processing after FIFO
// R8 - Domain release synchronised to own clock
module domain_reset_fifo_clock_select (
   input  wire  logic       sys_clk,
   input  wire  logic       sys_rst,
   input  wire  logic       porRst_n,
   input  wire  logic       frontClk,
   input  wire  logic       backClk,
   input  wire  logic       oifClk,
   input  wire  logic       dviClk,
   input  wire  logic [0:0] cfgPage,
   input  wire  logic [7:0] cfgAddr,
   input  wire  logic       cfgWrite,
   input  wire  logic       cfgRead,
   input  wire  logic [7:0] cfgWrData,
   output logic       [7:0] cfgRdData,
   output logic             chipReset,
   output logic             frontReset,
   output logic             backReset,
   output logic             oifReset,
   output logic             dviReset,
   output logic             fifoUseFront,
   output logic             pixelClk
);
   import domain_reset_pkg::*;
   logic [7:0] resetCtrl_r;
   logic [7:0] fifoSel_r;
   logic [7:0] rdData_nxt;
   logic       chipHold;
   domain_reset_if dom [4] ();

   // ----------------------------------------------------
   // Chip reset
   // ----------------------------------------------------
   assign chipHold  = sys_rst || !porRst_n; // [R1]
   assign chipReset = chipHold;

   function automatic logic hit(input logic [7:0] a);
      hit = (cfgPage == PageClockMgmt) && (cfgAddr == a); // [R6]
   endfunction

   // ----------------------------------------------------
   // Register writes
   // ----------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (chipHold) begin
         resetCtrl_r <= ResetCtrlInit; // [R1]
      end else if (cfgWrite && hit(RegResetCtrlAddr)) begin
         resetCtrl_r <= cfgWrData;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (chipHold) begin
         fifoSel_r <= FifoSelInit;
      end else if (cfgWrite && hit(RegFifoSelAddr)) begin
         fifoSel_r <= cfgWrData;
      end
   end

   // ----------------------------------------------------
   // Register reads
   // ----------------------------------------------------
   always_comb begin
      rdData_nxt = ReadUnmapped;
      if (hit(RegResetCtrlAddr)) rdData_nxt = resetCtrl_r;
      if (hit(RegFifoSelAddr))   rdData_nxt = fifoSel_r;
      if (hit(RegVersionHiAddr)) rdData_nxt = ChipVersionCode[15:8]; // [R5]
      if (hit(RegVersionLoAddr)) rdData_nxt = ChipVersionCode[7:0];  // [R5]
   end
   always_ff @(posedge sys_clk) begin
      if (chipHold) begin
         cfgRdData <= ReadUnmapped;
      end else if (cfgRead) begin
         cfgRdData <= rdData_nxt;
      end
   end

   // ----------------------------------------------------
   // Domain resets
   // ----------------------------------------------------
   assign dom[0].domClk   = frontClk;
   assign dom[1].domClk   = backClk;
   assign dom[2].domClk   = oifClk;
   assign dom[3].domClk   = dviClk;
   assign dom[0].resetReq = chipHold || resetCtrl_r[BitResetFront]; // [R2]
   assign dom[1].resetReq = chipHold || resetCtrl_r[BitResetBack];  // [R2]
   assign dom[2].resetReq = chipHold || resetCtrl_r[BitResetOif];   // [R2]
   assign dom[3].resetReq = chipHold || resetCtrl_r[BitResetDvi];   // [R2]
   for (genvar i = 0; i < 4; i++) begin : g_sync
      domain_reset_sync u_sync (.port(dom[i]));
   end
   assign frontReset = dom[0].domReset;
   assign backReset  = dom[1].domReset;
   assign oifReset   = dom[2].domReset;
   assign dviReset   = dom[3].domReset;

   // ----------------------------------------------------
   // FIFO and pixel clock selection
   // ----------------------------------------------------
   assign fifoUseFront = fifoSel_r[BitFifoFront]; // [R3]
   assign pixelClk     = backClk; // [R7]
endmodule
`default_nettype wire

//--- domain_reset_pkg.sv
// Package with register map, field positions and reset values for the domain reset block
package domain_reset_pkg;
   localparam logic [7:0] RegResetCtrlAddr = 8'hFC;
   localparam logic [7:0] RegFifoSelAddr   = 8'hFD;
   localparam logic [7:0] RegVersionHiAddr = 8'hFE;
   localparam logic [7:0] RegVersionLoAddr = 8'hFF;
   localparam logic [0:0] PageClockMgmt    = 1'h0;
   localparam int         BitResetFront    = 0;
   localparam int         BitResetBack     = 1;
   localparam int         BitResetOif      = 2;
   localparam int         BitResetDvi      = 3;
   localparam int         BitFifoFront     = 0;
   localparam logic [7:0] ResetCtrlInit    = 8'h00;
   localparam logic [7:0] FifoSelInit      = 8'h00;
   // Arbitrary neutral version code
   localparam logic [15:0] ChipVersionCode = 16'h0A5A;
   localparam logic [7:0] ReadUnmapped     = 8'h00;
   typedef enum logic [1:0] {
      SYNC_HOLD = 2'b01,
      SYNC_RUN  = 2'b10
   } sync_state_type;
endpackage

//--- domain_reset_if.sv
// Interface carrying one domain's reset request and clock
`timescale 1ns/1ps
`default_nettype none
interface domain_reset_if;
   logic domClk;
   logic resetReq;
   logic domReset;
   modport ctrl (output resetReq, input domClk, input domReset);
   modport sync (input resetReq, input domClk, output domReset);
endinterface
`default_nettype wire

//--- domain_reset_sync.sv
// Reset release synchroniser for one clock domain
`timescale 1ns/1ps
`default_nettype none
module domain_reset_sync (
   domain_reset_if.sync port
);
   import domain_reset_pkg::*;
   logic           stage1_r;
   logic           stage2_r;
   sync_state_type state_r;
   // ----------------------------------------------------
   // Assert at once, release on domain clock
   // ----------------------------------------------------
   always_ff @(posedge port.domClk) begin
      stage1_r <= port.resetReq;
      stage2_r <= stage1_r;
   end
   always_ff @(posedge port.domClk) begin
      unique case (state_r)
         SYNC_HOLD: if (!stage2_r) state_r <= SYNC_RUN; // [R8]
         SYNC_RUN:  if (stage2_r) state_r <= SYNC_HOLD;
         default:   state_r <= SYNC_HOLD;
      endcase
   end
   assign port.domReset = port.resetReq || (state_r != SYNC_RUN); // [R2] [R8]
endmodule
`default_nettype wire

//--- domain_reset_fifo_clock_select_assertions.sv
// Checker for domain resets, FIFO select and version readback
`timescale 1ns/1ps
`default_nettype none
module domain_reset_fifo_clock_select_assertions import domain_reset_pkg::*; (
   input wire logic       sys_clk, sys_rst, porRst_n, backClk, cfgWrite, cfgRead,
   input wire logic [0:0] cfgPage,
   input wire logic [7:0] cfgAddr, cfgWrData, cfgRdData,
   input wire logic       chipReset, frontReset, backReset, fifoUseFront, pixelClk
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (chipReset);
   sequence sAcc(s, logic [7:0] a);
      s && cfgPage == PageClockMgmt && cfgAddr == a;
   endsequence
   a_por_hold: assert property (disable iff (sys_rst)
      !porRst_n |-> chipReset && frontReset && backReset) else $error("por hold");
   a_front_hold: assert property (sAcc(cfgWrite, RegResetCtrlAddr)
      ##0 cfgWrData[BitResetFront] |=> frontReset) else $error("front hold");
   a_fifo_sel: assert property (sAcc(cfgWrite, RegFifoSelAddr) |=>
      fifoUseFront == $past(cfgWrData[BitFifoFront])) else $error("fifo sel");
   a_version_hi: assert property (sAcc(cfgRead, RegVersionHiAddr) |=>
      cfgRdData == ChipVersionCode[15:8]) else $error("version");
   a_page_refuse: assert property (cfgRead && cfgPage != PageClockMgmt |=>
      cfgRdData == ReadUnmapped) else $error("page refuse");
   a_pixel_clock: assert property (pixelClk == backClk) else $error("pixel clk");
   a_release_sync: assert property ($fell(chipReset) |-> frontReset[*2])
      else $error("release");
endmodule
bind domain_reset_fifo_clock_select domain_reset_fifo_clock_select_assertions u_chk (.*);
`default_nettype wire

//--- cfg_host_model.sv
// Configuration host model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] cfgRdData,
   output var  logic [0:0] cfgPage,
   output var  logic [7:0] cfgAddr, cfgWrData,
   output var  logic       cfgWrite, cfgRead
);
   initial {cfgPage, cfgAddr, cfgWrData, cfgWrite, cfgRead} = '0;
   // Strobe held for one edge, answer read after it
   task automatic acc(input logic [0:0] p, input logic [7:0] a, d, input logic w);
      @(posedge sys_clk);
      {cfgPage, cfgAddr, cfgWrData, cfgWrite, cfgRead} <= {p, a, d, w, !w};
      @(posedge sys_clk);
      {cfgWrite, cfgRead} <= 2'h0;
      #1;
   endtask
endmodule
`default_nettype wire

//--- test_domain_reset_fifo_clock_select.sv
// Testbench for domain resets, FIFO clock select and version readback
`timescale 1ns/1ps
`default_nettype none
module test_domain_reset_fifo_clock_select;
   import domain_reset_pkg::*;
   logic sys_clk = 0, sys_rst = 1, porRst_n = 1, frontClk = 0, backClk = 0, oifClk = 0, dviClk = 0;
   logic [0:0] cfgPage;
   logic [7:0] cfgAddr, cfgWrData, cfgRdData, v;
   logic cfgWrite, cfgRead, chipReset, frontReset, backReset, oifReset, dviReset, fifoUseFront, pixelClk;
   wire [7:0] rstVec = {3'h0, chipReset, dviReset, oifReset, backReset, frontReset};
   int failures = 0, tests_run = 0, seed = 35, frontHalf = 7;
   localparam int BackHalf = 4;
   initial forever #5 sys_clk = ~sys_clk;
   initial forever #(frontHalf) frontClk = ~frontClk;
   initial forever #(BackHalf) backClk = ~backClk;
   initial forever #6 oifClk = ~oifClk;
   initial forever #9 dviClk = ~dviClk;
   domain_reset_fifo_clock_select u_dut (.*);
   cfg_host_model u_host (.*);
   function automatic logic [7:0] expRst(input logic [7:0] r, input logic c);
      return c ? 8'h1F : {4'h0, r[3:0]};
   endfunction
   function automatic logic expSel(input int f, b);
      return f < b;
   endfunction
   task automatic chk(input string n, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      failures++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      chk("reset hold", expRst(0, 1), rstVec);
      sys_rst <= 1'b0;
      repeat (10) @(posedge sys_clk);
      #1 chk("released", expRst(0, 0), rstVec);
      for (int i = 0; i < 12; i++) begin
         v = (i < 2) ? (i ? 8'h0F : 8'h01) : {4'h0, 4'($random(seed))};
         u_host.acc(1'h0, RegResetCtrlAddr, v, 1'b1);
         repeat (10) @(posedge sys_clk);
         #1 chk("domain resets", expRst(v, 0), rstVec);
         u_host.acc(1'h0, RegResetCtrlAddr, 8'h00, 1'b0);
         chk("reset reg", v, cfgRdData);
      end
      for (int s = 1; s >= 0; s--) begin
         frontHalf = s ? 3 : 7;
         u_host.acc(1'h0, RegFifoSelAddr, 8'(expSel(frontHalf, BackHalf)), 1'b1);
         chk("fifo select", 8'(s), {7'h0, fifoUseFront});
      end
      u_host.acc(1'h0, RegVersionHiAddr, 8'h00, 1'b0);
      chk("version hi", ChipVersionCode[15:8], cfgRdData);
      u_host.acc(1'h0, RegVersionLoAddr, 8'h00, 1'b0);
      chk("version lo", ChipVersionCode[7:0], cfgRdData);
      u_host.acc(1'h1, RegVersionHiAddr, 8'h00, 1'b0);
      chk("page one read", 8'h00, cfgRdData);
      u_host.acc(1'h1, RegResetCtrlAddr, ~v, 1'b1);
      u_host.acc(1'h0, RegResetCtrlAddr, 8'h00, 1'b0);
      chk("page one write", v, cfgRdData);
      chk("page one resets", expRst(v, 0), rstVec);
      u_host.acc(1'h0, 8'h10, 8'h00, 1'b0);
      chk("unmapped read", 8'h00, cfgRdData);
      porRst_n <= 1'b0;
      @(posedge sys_clk);
      #1 chk("por", expRst(0, 1), rstVec);
      @(posedge sys_clk);
      porRst_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      #1 chk("por released", expRst(0, 0), rstVec);
      u_host.acc(1'h0, RegResetCtrlAddr, 8'h00, 1'b0);
      chk("por reg clear", ResetCtrlInit, cfgRdData);
      report_and_stop;
   end
endmodule
`default_nettype wire
